/* File: hw/cmbs_buffer_store.sv */
// Message buffer store of a CAN controller: three transmit buffers with
// payload, length code, frame kind, local priority and time stamp, the
// scheduler that picks the next buffer, and a free-running stamp timer.
// Assumes an Avalon-MM master on the register port and a protocol engine
// on the same clock that requests frames and bytes with one-cycle pulses.
//
// Notes on behaviour
// - Each buffer holds eight payload bytes; only length-code many, eight at most, are sent.
// - Length code 0..8 gives that many bytes; field is bits 3..0.
// - Remote frames send the programmed length code but no payload bytes.
// - Buffers with empty flag cleared compete right before each start of frame.
// - The competitor with the numerically smallest local priority wins.
// - Equal smallest priorities go to the lowest buffer index.
// - Priority resets to zero; access only when selected buffer is empty.
// - With stamping on, the timer value is stored after a valid frame end.
// - Stamp timer counts bit ticks, wraps silently, clears in init mode.
// - The 16-bit stamp is read-only, high byte and low byte.
// - Three independent transmit buffers allow back-to-back frames.
// - Frame kind bit 0 sends a data frame, 1 a remote frame.
// - Software clears the empty flag; success sets it again.
`timescale 1ns/100ps

module cmbs_buffer_store (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [cmbs_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [cmbs_pkg::DATA_W-1:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [cmbs_pkg::DATA_W-1:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic TX_SOF_REQ,
    input wire logic TX_BYTE_REQ,
    input wire logic TX_DONE,
    input wire logic TX_FAIL,
    input wire logic RX_EOF_OK,
    input wire logic BIT_TICK,
    output cmbs_pkg::cmbs_tx_desc_t TX_DESC,
    output logic TX_VALID,
    output logic [cmbs_pkg::BYTE_W-1:0] TX_BYTE,
    output logic TX_BYTE_VALID,
    output logic [cmbs_pkg::STAMP_W-1:0] RX_STAMP,
    output logic RX_STAMP_VALID,
    output logic [cmbs_pkg::NUM_TXBUF-1:0] TX_EMPTY,
    output logic IRQ
);
    import cmbs_pkg::*;

    localparam int N = NUM_TXBUF;

    logic [N-1:0][NUM_PAYLOAD-1:0][BYTE_W-1:0] payload_reg;
    logic [N-1:0][DLC_W-1:0] length_reg;
    logic [N-1:0][PRIORITY_VALUE_W-1:0] priority_value_reg;
    logic [N-1:0][STAMP_W-1:0] stamp_reg;
    logic [N-1:0] remote_reg;
    logic [N-1:0] txe_reg, txe_next, sel_reg, irq_stat_reg, irq_stat_next, irq_en_reg;
    logic [CTRL_W-1:0] ctrl_reg;
    logic [STAMP_W-1:0] timer_reg;
    cmbs_tx_state_t state_reg;
    logic [BUF_W-1:0] act_reg;
    logic [BCNT_W-1:0] sent_reg;
    logic waitreq_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [BYTE_W-1:0] rd_val;
    logic [N-1:0] sel_mask, done_set, flag_clr, irq_clr;
    logic arb_valid, arb_bad_less, arb_bad_tie;
    logic [BUF_W-1:0] arb_idx;

    // Index of the lowest set bit; used for the select window only.
    function automatic logic [BUF_W-1:0] first_set(input logic [N-1:0] v);
        first_set = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = BUF_W'(i);
            end
        end
    endfunction

    // Bytes that go on the bus; codes above eight still mean eight bytes.
    function automatic logic [BCNT_W-1:0] bytes_for(input logic [DLC_W-1:0] len,
                                                   input logic remote);
        if (remote) begin
            bytes_for = '0;
        end else if (len > DLC_MAX_BYTES) begin
            bytes_for = BCNT_W'(DLC_MAX_BYTES);
        end else begin
            bytes_for = BCNT_W'(len);
        end
    endfunction

    wire [IDX_W-1:0] idx = AVS_ADDRESS[ADDR_W-1:2];
    wire [BYTE_W-1:0] wd = AVS_WRITEDATA[BYTE_W-1:0];
    wire wr_go = AVS_WRITE && !waitreq_reg && AVS_BYTEENABLE[0];
    wire [BUF_W-1:0] sel_idx = first_set(sel_reg);
    wire sel_ok = |sel_reg;
    wire win_ok = sel_ok && txe_reg[sel_idx];
    wire init_mode = ctrl_reg[CTRL_INIT_BIT];
    wire time_en = ctrl_reg[CTRL_TIME_BIT];
    wire busy = (state_reg == CMBS_TX_BUSY);
    wire start = (state_reg == CMBS_TX_IDLE) && TX_SOF_REQ && !init_mode && arb_valid;
    wire tx_ok = busy && TX_DONE;
    wire [IDX_W-1:0] pl_off = idx - IDX_PAYLOAD0;

    assign AVS_READDATA = rdata_reg;
    assign AVS_WAITREQUEST = waitreq_reg;
    assign TX_EMPTY = txe_reg;

    // Scheduler over all non-empty buffers.
    cmbs_tx_arbiter #(
        .N(N),
        .PW(PRIORITY_VALUE_W),
        .IW(BUF_W)
    ) u_arb (
        .ready(~txe_reg),
        .priority_value(priority_value_reg),
        .win_valid(arb_valid),
        .win_idx(arb_idx)
    );

    // Each access waits one cycle so that read data come from a register.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            waitreq_reg <= 1'b1;
            rdata_reg <= '0;
        end else begin
            waitreq_reg <= !((AVS_READ || AVS_WRITE) && waitreq_reg);
            if (AVS_READ && waitreq_reg) begin
                rdata_reg <= {{(DATA_W - BYTE_W){1'b0}}, rd_val};
            end
        end
    end

    // Read decode; unmapped words, and priority and stamps through a closed window, read as zero.
    always_comb begin
        rd_val = '0;
        if (idx >= IDX_PAYLOAD0 && idx <= IDX_PAYLOAD7) begin
            if (sel_ok) begin
                rd_val = payload_reg[sel_idx][pl_off[2:0]];
            end
        end else if (idx == IDX_FRAME_LENGTH) begin
            if (sel_ok) begin
                rd_val = BYTE_W'(length_reg[sel_idx]);
            end
        end else if (idx == IDX_LOCAL_PRIORITY_VALUE) begin
            if (win_ok) begin
                rd_val = priority_value_reg[sel_idx];
            end
        end else if (idx == IDX_STAMP_HIGH) begin
            if (win_ok) begin
                rd_val = stamp_reg[sel_idx][STAMP_W-1:STAMP_HIGH_LSB];
            end
        end else if (idx == IDX_STAMP_LOW) begin
            if (win_ok) begin
                rd_val = stamp_reg[sel_idx][STAMP_HIGH_LSB-1:0];
            end
        end else if (idx == IDX_FRAME_KIND) begin
            if (sel_ok) begin
                rd_val = BYTE_W'(remote_reg[sel_idx]);
            end
        end else if (idx == IDX_TX_FLAG) begin
            rd_val = BYTE_W'(txe_reg);
        end else if (idx == IDX_TX_SELECT) begin
            rd_val = BYTE_W'(sel_reg);
        end else if (idx == IDX_CONTROL) begin
            rd_val = BYTE_W'(ctrl_reg);
        end else if (idx == IDX_IRQ_STATUS) begin
            rd_val = BYTE_W'(irq_stat_reg);
        end else if (idx == IDX_IRQ_ENABLE) begin
            rd_val = BYTE_W'(irq_en_reg);
        end
    end

    // Buffer contents change only through an open window, so a buffer that
    // waits for or is in transmission cannot be altered under the engine.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            payload_reg <= '0;
            length_reg <= '0;
            priority_value_reg <= {N{PRIORITY_VALUE_RESET}};
            remote_reg <= '0;
        end else if (wr_go && win_ok) begin
            if (idx >= IDX_PAYLOAD0 && idx <= IDX_PAYLOAD7) begin
                payload_reg[sel_idx][pl_off[2:0]] <= wd;
            end else if (idx == IDX_FRAME_LENGTH) begin
                length_reg[sel_idx] <= wd[DLC_W-1:0];
            end else if (idx == IDX_LOCAL_PRIORITY_VALUE) begin
                priority_value_reg[sel_idx] <= wd;
            end else if (idx == IDX_FRAME_KIND) begin
                remote_reg[sel_idx] <= wd[KIND_REMOTE_BIT];
            end
        end
    end

    // Selecting picks the lowest requested buffer that is empty, or none.
    assign sel_mask = wd[N-1:0] & txe_reg;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sel_reg <= '0;
            ctrl_reg <= CTRL_RESET;
            irq_en_reg <= '0;
        end else if (wr_go) begin
            if (idx == IDX_TX_SELECT) begin
                sel_reg <= sel_mask & (~sel_mask + ONE_HOT_LSB);
            end else if (idx == IDX_CONTROL) begin
                ctrl_reg <= wd[CTRL_W-1:0];
            end else if (idx == IDX_IRQ_ENABLE) begin
                irq_en_reg <= wd[N-1:0];
            end
        end
    end

    // Empty flags and completion status: a success in the same cycle as a
    // software clear wins, so no completion is ever lost.
    always_comb begin
        done_set = tx_ok ? (ONE_HOT_LSB << act_reg) : '0;
        flag_clr = (wr_go && idx == IDX_TX_FLAG) ? wd[N-1:0] : '0;
        irq_clr = (wr_go && idx == IDX_IRQ_CLEAR) ? wd[N-1:0] : '0;
        txe_next = (txe_reg & ~flag_clr) | done_set;
        irq_stat_next = (irq_stat_reg & ~irq_clr) | done_set;
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            txe_reg <= TXE_RESET;
            irq_stat_reg <= '0;
            IRQ <= 1'b0;
        end else begin
            txe_reg <= txe_next;
            irq_stat_reg <= irq_stat_next;
            IRQ <= |(irq_stat_reg & irq_en_reg);
        end
    end

    // Stamp timer on the bit tick; it wraps with no overrun indication.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            timer_reg <= STAMP_ZERO;
        end else if (init_mode) begin
            timer_reg <= STAMP_ZERO;
        end else if (BIT_TICK) begin
            timer_reg <= timer_reg + 1'b1;
        end
    end

    // Stamps are taken right after a valid end of frame.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            stamp_reg <= '0;
            RX_STAMP <= STAMP_ZERO;
            RX_STAMP_VALID <= 1'b0;
        end else begin
            RX_STAMP_VALID <= RX_EOF_OK && time_en;
            if (tx_ok && time_en) begin
                stamp_reg[act_reg] <= timer_reg;
            end
            if (RX_EOF_OK && time_en) begin
                RX_STAMP <= timer_reg;
            end
        end
    end

    // Frame sequencer. A failed attempt returns to idle with the buffer still
    // pending, so the next start of frame schedules afresh.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_reg <= CMBS_TX_IDLE;
            act_reg <= '0;
            TX_VALID <= 1'b0;
            TX_DESC <= '0;
        end else begin
            case (state_reg)
                CMBS_TX_IDLE: begin
                    if (start) begin
                        state_reg <= CMBS_TX_BUSY;
                        act_reg <= arb_idx;
                        TX_VALID <= 1'b1;
                        TX_DESC.bufnum <= arb_idx;
                        TX_DESC.length_code <= length_reg[arb_idx];
                        TX_DESC.remote <= remote_reg[arb_idx];
                        TX_DESC.byte_count <= bytes_for(length_reg[arb_idx], remote_reg[arb_idx]);
                    end
                end
                CMBS_TX_BUSY: begin
                    if (TX_DONE || TX_FAIL) begin
                        state_reg <= CMBS_TX_IDLE;
                        TX_VALID <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= CMBS_TX_IDLE;
                    TX_VALID <= 1'b0;
                end
            endcase
        end
    end

    // Payload stream; requests beyond the byte count get no valid byte.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sent_reg <= '0;
            TX_BYTE <= '0;
            TX_BYTE_VALID <= 1'b0;
        end else begin
            TX_BYTE_VALID <= 1'b0;
            if (start) begin
                sent_reg <= '0;
            end else if (busy && TX_BYTE_REQ && sent_reg < TX_DESC.byte_count) begin
                TX_BYTE <= payload_reg[act_reg][sent_reg[2:0]];
                TX_BYTE_VALID <= 1'b1;
                sent_reg <= sent_reg + BCNT_ONE;
            end
        end
    end

    // Reference check on the arbiter result for the assertions below.
    always_comb begin
        arb_bad_less = 1'b0;
        arb_bad_tie = 1'b0;
        for (int j = 0; j < N; j++) begin
            if (!txe_reg[j] && priority_value_reg[j] < priority_value_reg[arb_idx]) begin
                arb_bad_less = 1'b1;
            end
            if (!txe_reg[j] && priority_value_reg[j] == priority_value_reg[arb_idx] && BUF_W'(j) < arb_idx) begin
                arb_bad_tie = 1'b1;
            end
        end
    end

    a_byte_limit: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        TX_BYTE_VALID |-> sent_reg <= TX_DESC.byte_count && sent_reg != '0)
        else $error("More payload bytes sent than the length code allows.");

    a_length_map: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        $rose(TX_VALID) && !TX_DESC.remote |->
        TX_DESC.byte_count == ((TX_DESC.length_code > DLC_MAX_BYTES) ?
            BCNT_W'(DLC_MAX_BYTES) : BCNT_W'(TX_DESC.length_code)))
        else $error("Byte count does not follow the length code.");

    a_remote_nodata: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        TX_VALID && TX_DESC.remote |-> TX_DESC.byte_count == '0 ##1 !TX_BYTE_VALID)
        else $error("Remote frame carries payload bytes.");

    a_sched_pending: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        start |=> TX_VALID && !txe_reg[TX_DESC.bufnum] && TX_DESC.bufnum == $past(arb_idx))
        else $error("Scheduled buffer was not a pending one.");

    a_priority_value_smallest: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        arb_valid |-> !arb_bad_less && !txe_reg[arb_idx])
        else $error("A pending buffer with smaller priority lost.");

    a_priority_value_tie: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        arb_valid |-> !arb_bad_tie)
        else $error("Priority tie not won by the lowest index.");

    a_priority_value_locked: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        wr_go && idx == IDX_LOCAL_PRIORITY_VALUE && !win_ok |=> $stable(priority_value_reg))
        else $error("Priority changed through a closed window.");

    a_stamp_take: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        tx_ok && time_en |=>
        stamp_reg[$past(act_reg)] == $past(timer_reg) && txe_reg[$past(act_reg)])
        else $error("Stamp not taken at successful frame end.");

    a_timer_init: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        init_mode ##1 init_mode |-> timer_reg == STAMP_ZERO)
        else $error("Stamp timer runs in initialization mode.");

    a_stamp_ro: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        wr_go && (idx == IDX_STAMP_HIGH || idx == IDX_STAMP_LOW) && !tx_ok |=> $stable(stamp_reg))
        else $error("Stamp register changed by a write.");

    a_empty_set: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        busy && TX_DONE |=> txe_reg[$past(act_reg)] && !TX_VALID ##1 !TX_BYTE_VALID)
        else $error("Empty flag not set after successful transmission.");

endmodule

/* File: hw/cmbs_tx_arbiter.sv */
// Local priority arbiter over the transmit buffers.
// Assumes the caller samples its result right before start of frame.
`timescale 1ns/100ps

module cmbs_tx_arbiter #(
    parameter int N = cmbs_pkg::NUM_TXBUF,
    parameter int PW = cmbs_pkg::PRIORITY_VALUE_W,
    parameter int IW = cmbs_pkg::BUF_W
) (
    input wire logic [N-1:0] ready,
    input wire logic [N-1:0][PW-1:0] priority_value,
    output logic win_valid,
    output logic [IW-1:0] win_idx
);

    logic [PW-1:0] best;

    // Ascending scan with a strict compare, so an equal value never displaces
    // an earlier buffer and the lowest index wins a tie.
    always_comb begin
        win_valid = 1'b0;
        win_idx = '0;
        best = '0;
        for (int i = 0; i < N; i++) begin
            if (ready[i] && (!win_valid || priority_value[i] < best)) begin
                win_valid = 1'b1;
                win_idx = IW'(i);
                best = priority_value[i];
            end
        end
    end

endmodule

/* File: inc/cmbs_pkg.sv */
// Constants, types and register map of the CAN message buffer store.
// Assumes a 32-bit Avalon-MM slave port and one 40 MHz system clock.
package cmbs_pkg;

    // Structure of the buffer store.
    localparam int NUM_TXBUF = 3;
    localparam int NUM_PAYLOAD = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IDX_W = 6;
    localparam int PRIORITY_VALUE_W = 8;
    localparam int STAMP_W = 16;
    localparam int DLC_W = 4;
    localparam int BCNT_W = 4;
    localparam int BUF_W = 2;
    localparam int BYTE_W = 8;
    localparam int CTRL_W = 2;
    localparam int CLK_MHZ = 40;

    // Register indexes; the byte address is four times the index.
    localparam logic [IDX_W-1:0] IDX_PAYLOAD0 = 6'h04;
    localparam logic [IDX_W-1:0] IDX_PAYLOAD7 = 6'h0b;
    localparam logic [IDX_W-1:0] IDX_FRAME_LENGTH = 6'h0c;
    localparam logic [IDX_W-1:0] IDX_LOCAL_PRIORITY_VALUE = 6'h0d;
    localparam logic [IDX_W-1:0] IDX_STAMP_HIGH = 6'h0e;
    localparam logic [IDX_W-1:0] IDX_STAMP_LOW = 6'h0f;
    localparam logic [IDX_W-1:0] IDX_FRAME_KIND = 6'h10;
    localparam logic [IDX_W-1:0] IDX_TX_FLAG = 6'h20;
    localparam logic [IDX_W-1:0] IDX_TX_SELECT = 6'h21;
    localparam logic [IDX_W-1:0] IDX_CONTROL = 6'h22;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 6'h23;
    localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 6'h24;
    localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR = 6'h25;

    // Field positions.
    localparam int CTRL_INIT_BIT = 0;
    localparam int CTRL_TIME_BIT = 1;
    localparam int KIND_REMOTE_BIT = 0;
    localparam int STAMP_HIGH_LSB = 8;

    // Reset values and fixed codes.
    localparam logic [PRIORITY_VALUE_W-1:0] PRIORITY_VALUE_RESET = 8'h00;
    localparam logic [NUM_TXBUF-1:0] TXE_RESET = 3'h7;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h1;
    localparam logic [DLC_W-1:0] DLC_MAX_BYTES = 4'h8;
    localparam logic [NUM_TXBUF-1:0] ONE_HOT_LSB = 3'h1;
    localparam logic [STAMP_W-1:0] STAMP_ZERO = 16'h0000;
    localparam logic [BCNT_W-1:0] BCNT_ONE = 4'h1;

    // Transmit sequencer states.
    typedef enum logic [1:0] {
        CMBS_TX_IDLE = 2'b01,
        CMBS_TX_BUSY = 2'b10
    } cmbs_tx_state_t;

    // Frame description handed to the protocol engine at start of frame.
    typedef struct packed {
        logic [BUF_W-1:0] bufnum;
        logic [DLC_W-1:0] length_code;
        logic remote;
        logic [BCNT_W-1:0] byte_count;
    } cmbs_tx_desc_t;

endpackage

/* File: verif/cmbs_buffer_store_tb.sv */
// Self-checking bench for the message buffer store: register bus and engine.
// Assumes the engine model in its own file and the shared package.
`timescale 1ns/100ps
module cmbs_buffer_store_tb;
    import cmbs_pkg::*;
    localparam int LEN [3] = '{3, 8, 5};
    localparam int PRI [3] = '{5, 3, 3};
    localparam int KND [3] = '{0, 0, 1};
    logic CLK = 1'b0;
    logic ARST_N = 1'b0;
    logic [ADDR_W-1:0] AVS_ADDRESS = '0;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [DATA_W-1:0] AVS_WRITEDATA = '0;
    logic [3:0] AVS_BYTEENABLE = 4'hf;
    logic [DATA_W-1:0] AVS_READDATA;
    logic AVS_WAITREQUEST;
    logic TX_SOF_REQ, TX_BYTE_REQ, TX_DONE, TX_FAIL;
    logic RX_EOF_OK = 1'b0;
    logic BIT_TICK = 1'b0;
    cmbs_tx_desc_t TX_DESC;
    logic TX_VALID, TX_BYTE_VALID, RX_STAMP_VALID, IRQ;
    logic [BYTE_W-1:0] TX_BYTE;
    logic [STAMP_W-1:0] RX_STAMP;
    logic [NUM_TXBUF-1:0] TX_EMPTY;
    logic wq;
    logic [DATA_W-1:0] rq;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;

    // A 40 MHz clock.
    always #12.5 CLK = ~CLK;

    cmbs_buffer_store cmbs_buffer_store_i (.CLK(CLK), .ARST_N(ARST_N),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .TX_SOF_REQ(TX_SOF_REQ), .TX_BYTE_REQ(TX_BYTE_REQ), .TX_DONE(TX_DONE),
        .TX_FAIL(TX_FAIL), .RX_EOF_OK(RX_EOF_OK), .BIT_TICK(BIT_TICK), .TX_DESC(TX_DESC),
        .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE), .TX_BYTE_VALID(TX_BYTE_VALID),
        .RX_STAMP(RX_STAMP), .RX_STAMP_VALID(RX_STAMP_VALID), .TX_EMPTY(TX_EMPTY), .IRQ(IRQ));

    cmbs_eng_model cmbs_eng_model_i (.CLK(CLK), .TX_DESC(TX_DESC), .TX_VALID(TX_VALID),
        .TX_BYTE(TX_BYTE), .TX_BYTE_VALID(TX_BYTE_VALID), .TX_SOF_REQ(TX_SOF_REQ),
        .TX_BYTE_REQ(TX_BYTE_REQ), .TX_DONE(TX_DONE), .TX_FAIL(TX_FAIL));

    // Bus answers are copied mid-cycle so the rising edge sees them without a race.
    always @(negedge CLK) begin
        wq <= AVS_WAITREQUEST;
        rq <= AVS_READDATA;
    end

    // Watchdog: the wrap test alone needs about 65k cycles.
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 80000) begin
            err_count++;
            $display("Error at %0t: timeout", $time);
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Request held until waitrequest is seen low at a rising edge.
    task automatic bus(input bit w, input int idx, input int d, output logic [7:0] q);
        @(posedge CLK);
        AVS_ADDRESS <= {IDX_W'(idx), 2'b00};
        AVS_WRITE <= w;
        AVS_READ <= !w;
        AVS_WRITEDATA <= DATA_W'(d);
        // Only the bench watchdog ends a wait that never gets an answer.
        do begin
            @(posedge CLK);
        end while (wq !== 1'b0);
        q = rq[7:0];
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask

    task automatic wr(input int idx, input int d);
        logic [7:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic rdc(input int idx, input int exp);
        logic [7:0] q;
        bus(1'b0, idx, 0, q);
        chk(q, exp, "register read");
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge CLK) BIT_TICK <= 1'b1;
        @(posedge CLK) BIT_TICK <= 1'b0;
    endtask

    task automatic rx_stamp(input int exp);
        @(posedge CLK) RX_EOF_OK <= 1'b1;
        @(posedge CLK) RX_EOF_OK <= 1'b0;
        @(negedge CLK);
        chk(RX_STAMP, exp, "receive stamp");
        chk(RX_STAMP_VALID, 1, "receive stamp valid");
    endtask

    task automatic frame(input bit fail, input int b, input int code, input bit rem,
                         input int cnt);
        cmbs_eng_model_i.run(fail);
        @(negedge CLK);
        chk(cmbs_eng_model_i.desc, {b[1:0], code[3:0], rem, cnt[3:0]}, "descriptor");
        chk(cmbs_eng_model_i.nbytes, cnt, "byte count");
        for (int i = 0; i < cnt; i++) begin
            chk(cmbs_eng_model_i.bytes[i], 8'h10 * b + i, "payload byte");
        end
        $display("Test frame from buffer %0d done", b);
    endtask

    // Main sequence.
    initial begin
        repeat (10) @(posedge CLK);
        ARST_N <= 1'b1;
        @(negedge CLK);
        chk(TX_EMPTY, 3'h7, "empty flags");
        rdc(IDX_CONTROL, 8'h01);
        rdc(6'h3f, 8'h00);
        for (int b = 0; b < 3; b++) begin
            wr(IDX_TX_SELECT, 1 << b);
            rdc(IDX_LOCAL_PRIORITY_VALUE, 8'h00);
            for (int i = 0; i < 8; i++) wr(IDX_PAYLOAD0 + i, 8'h10 * b + i);
            wr(IDX_FRAME_LENGTH, LEN[b]);
            wr(IDX_FRAME_KIND, KND[b]);
            wr(IDX_LOCAL_PRIORITY_VALUE, PRI[b]);
        end
        rdc(IDX_LOCAL_PRIORITY_VALUE, 8'h03);
        AVS_BYTEENABLE <= 4'h0;
        wr(IDX_LOCAL_PRIORITY_VALUE, 8'h44);
        AVS_BYTEENABLE <= 4'hf;
        rdc(IDX_LOCAL_PRIORITY_VALUE, 8'h03);
        wr(IDX_STAMP_HIGH, 8'hff);
        rdc(IDX_STAMP_HIGH, 8'h00);
        $display("Test register setup done");
        @(posedge CLK) RX_EOF_OK <= 1'b1;
        @(posedge CLK) RX_EOF_OK <= 1'b0;
        @(negedge CLK);
        chk(RX_STAMP_VALID, 0, "no stamp while stamping off");
        wr(IDX_CONTROL, 8'h02);
        wr(IDX_IRQ_ENABLE, 8'h07);
        tick(16'h0123);
        rx_stamp(16'h0123);
        wr(IDX_TX_FLAG, 8'h07);
        @(negedge CLK);
        chk(TX_EMPTY, 3'h0, "flags cleared");
        wr(IDX_TX_SELECT, 8'h02);
        rdc(IDX_TX_SELECT, 8'h00);
        frame(1'b1, 1, 8, 1'b0, 8);
        chk(TX_EMPTY, 3'h0, "pending after failure");
        tick(2);
        frame(1'b0, 1, 8, 1'b0, 8);
        chk(TX_EMPTY, 3'h2, "sent buffer empty");
        chk(IRQ, 1, "interrupt raised");
        rdc(IDX_IRQ_STATUS, 8'h02);
        wr(IDX_TX_SELECT, 8'h02);
        rdc(IDX_STAMP_HIGH, 8'h01);
        rdc(IDX_STAMP_LOW, 8'h25);
        wr(IDX_IRQ_CLEAR, 8'h02);
        wr(IDX_IRQ_ENABLE, 8'h03);
        repeat (2) @(negedge CLK);
        chk(IRQ, 0, "interrupt cleared");
        frame(1'b0, 2, 5, 1'b1, 0);
        chk(IRQ, 0, "interrupt masked");
        rdc(IDX_IRQ_STATUS, 8'h04);
        frame(1'b0, 0, 3, 1'b0, 3);
        chk(TX_EMPTY, 3'h7, "all empty");
        chk(IRQ, 1, "interrupt enabled source");
        wr(IDX_IRQ_CLEAR, 8'h05);
        rdc(IDX_IRQ_STATUS, 8'h00);
        @(negedge CLK);
        chk(IRQ, 0, "interrupt released");
        tick(32'h10000 - 32'h0125);
        rx_stamp(16'h0000);
        tick(4);
        wr(IDX_CONTROL, 8'h03);
        tick(3);
        rx_stamp(16'h0000);
        $display("Test stamp timer done");
        report_and_stop();
    end
endmodule

/* File: verif/cmbs_eng_model.sv */
// Protocol engine model: asks the buffer store for frames and payload bytes.
// Assumes registered store outputs, sampled at the falling clock edge.
`timescale 1ns/100ps
module cmbs_eng_model
    import cmbs_pkg::*;
(
    input wire logic CLK,
    input wire cmbs_pkg::cmbs_tx_desc_t TX_DESC,
    input wire logic TX_VALID,
    input wire logic [cmbs_pkg::BYTE_W-1:0] TX_BYTE,
    input wire logic TX_BYTE_VALID,
    output logic TX_SOF_REQ,
    output logic TX_BYTE_REQ,
    output logic TX_DONE,
    output logic TX_FAIL
);
    cmbs_tx_desc_t desc;
    logic [BYTE_W-1:0] bytes [NUM_PAYLOAD];
    int nbytes;

    // The engine is quiet until the bench asks for a frame.
    initial begin
        TX_SOF_REQ = 1'b0;
        TX_BYTE_REQ = 1'b0;
        TX_DONE = 1'b0;
        TX_FAIL = 1'b0;
    end

    // One attempt; one byte more is asked than announced, and it must stay unanswered.
    task automatic run(input bit fail);
        nbytes = 0;
        @(posedge CLK) TX_SOF_REQ <= 1'b1;
        @(posedge CLK) TX_SOF_REQ <= 1'b0;
        @(negedge CLK);
        desc = TX_DESC;
        for (int i = 0; i <= int'(desc.byte_count) && TX_VALID === 1'b1; i++) begin
            @(posedge CLK) TX_BYTE_REQ <= 1'b1;
            @(posedge CLK) TX_BYTE_REQ <= 1'b0;
            @(negedge CLK);
            if (TX_BYTE_VALID === 1'b1 && nbytes < NUM_PAYLOAD) begin
                bytes[nbytes] = TX_BYTE;
                nbytes++;
            end
        end
        @(posedge CLK) TX_DONE <= !fail;
        TX_FAIL <= fail;
        @(posedge CLK) TX_DONE <= 1'b0;
        TX_FAIL <= 1'b0;
        @(posedge CLK);
    endtask
endmodule
